// ### hdl/lec_top.sv
// Behaviour
// - four counters: line code, path, out-of-sync and far-end errors
// - updates on one second, short interval, or manual command
// - counters saturate at maximum, never wrap
// - automatic update raises update strobe and sticky update flag
// - config bit0 adds excessive zeros to T1 line counting
// - config bit1: framing-bit errors or multiframes out of sync
// - config bit2 adds signaling framing-bit errors to path count
// - config bit3: E1 bipolar violations or code violations
// - config bit4 picks interval bit or manual bit as update control
// - config bit5: one second, or 333 T1 / 500 E1 frames
// - manual bit rising edge loads held counts and clears counters next clock
// - T1 counts bipolar violations, not valid B8ZS codewords
// - T1 line counter runs during sync loss
// - excessive zeros: 16 zeros, or 8 with B8ZS
// - E1 bipolar violation: equal-polarity marks, HDB3 codewords excluded
// - E1 code violation: two successive violations of equal polarity
// - E1 line counter ignores sync loss, holds at 65,535
// - line count readable as upper and lower byte registers
// - T1 path counts CRC6 or Ft errors, disabled during sync loss
//
// Design decision made here: the AXI4-Lite interface to the registers.
`include "lec_params.svh"

module lec_top #(
  parameter int FRAMES_SECOND   = `LEC_FRAMES_SECOND,
  parameter int FRAMES_T1_SHORT = `LEC_FRAMES_T1_SHORT,
  parameter int FRAMES_E1_SHORT = `LEC_FRAMES_E1_SHORT
) (
  input  wire logic              sys_clk_i,
  input  wire logic              rst_i,
  input  wire logic [9:0]        s_axi_awaddr_i,
  input  wire logic              s_axi_awvalid_i,
  output logic                   s_axi_awready_o,
  input  wire logic [31:0]       s_axi_wdata_i,
  input  wire logic [3:0]        s_axi_wstrb_i,
  input  wire logic              s_axi_wvalid_i,
  output logic                   s_axi_wready_o,
  output logic [1:0]             s_axi_bresp_o,
  output logic                   s_axi_bvalid_o,
  input  wire logic              s_axi_bready_i,
  input  wire logic [9:0]        s_axi_araddr_i,
  input  wire logic              s_axi_arvalid_i,
  output logic                   s_axi_arready_o,
  output logic [31:0]            s_axi_rdata_o,
  output logic [1:0]             s_axi_rresp_o,
  output logic                   s_axi_rvalid_o,
  input  wire logic              s_axi_rready_i,
  input  wire logic              rclk_i,
  input  wire logic              rpos_i,
  input  wire logic              rneg_i,
  input  wire logic              t1_mode_i,
  input  wire logic              esf_mode_i,
  input  wire logic              b8zs_en_i,
  input  wire logic              hdb3_en_i,
  input  wire logic              receive_sync_lost_i,
  input  wire logic              frame_tick_i,
  input  wire logic              multiframe_tick_i,
  input  wire logic              crc_err_i,
  input  wire logic              ft_err_i,
  input  wire logic              fs_err_i,
  input  wire logic              fps_err_i,
  input  wire logic              fas_err_i,
  input  wire logic              far_end_err_i,
  output logic                   update_strobe_o
);
  import lec_pkg::*;

  localparam int NS = 17;
  localparam int W  = `LEC_CNT_WIDTH;

  lec_line_if                       lif ();
  lec_cnt_if #(.N(`LEC_NUM_CNT), .W(W)) cif ();

  logic [NS-1:0] raw;
  logic [NS-1:0] sync1_q;
  logic [NS-1:0] sync2_q;
  logic          rclk_d_q;
  logic          redge;
  logic [7:0]    cfg_q;
  logic          manual_q;
  logic          upd_flag_q;
  logic [12:0]   frame_cnt_q;
  logic [12:0]   frame_lim;
  logic          auto_hit;
  logic          man_hit;
  logic          snap;
  logic          s_rclk, s_pos, s_neg, s_t1, s_esf, s_b8zs, s_hdb3, s_lost;
  logic          s_frm, s_mf, s_crc, s_ft, s_fs, s_fps, s_fas, s_febe;
  logic          path_evt, sync_evt, febe_evt;

  assign raw = {rclk_i, rpos_i, rneg_i, t1_mode_i, esf_mode_i, b8zs_en_i, hdb3_en_i, receive_sync_lost_i,
                frame_tick_i, multiframe_tick_i, crc_err_i, ft_err_i, fs_err_i, fps_err_i, fas_err_i,
                far_end_err_i, 1'b0};
  assign {s_rclk, s_pos, s_neg, s_t1, s_esf, s_b8zs, s_hdb3, s_lost,
          s_frm, s_mf, s_crc, s_ft, s_fs, s_fps, s_fas, s_febe} = sync2_q[NS-1:1];

  // two-stage synchronisers for every line-side input pin; the AXI inputs are not synchronised
  for (genvar g = 0; g < NS; g++) begin : g_sync
    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        sync1_q[g] <= 1'b0;
        sync2_q[g] <= 1'b0;
      end else begin
        sync1_q[g] <= raw[g];
        sync2_q[g] <= sync1_q[g];
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      rclk_d_q <= 1'b0;
    end else begin
      rclk_d_q <= s_rclk;
    end
  end

  assign redge = s_rclk && !rclk_d_q;

  assign lif.sample        = redge;
  assign lif.rpos          = s_pos;
  assign lif.rneg          = s_neg;
  assign lif.t1_mode       = s_t1;
  assign lif.b8zs_en       = s_b8zs;
  assign lif.hdb3_en       = s_hdb3;
  assign lif.zero_count_en = cfg_q[`LEC_BIT_T1_ZERO];
  assign lif.cv_mode       = cfg_q[`LEC_BIT_E1_VTYPE];

  lec_line_decoder u_dec (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .lif       (lif)
  );

  always_comb begin
    if (s_t1) begin
      path_evt = s_esf ? s_crc : (s_ft || (cfg_q[`LEC_BIT_FS_REPORT] && s_fs));
      if (cfg_q[`LEC_BIT_SYNC_FN]) begin
        sync_evt = s_mf && s_lost;
      end else begin
        sync_evt = (s_esf ? s_fps : s_ft) && !s_lost;
      end
    end else begin
      path_evt = s_crc;
      sync_evt = s_fas && !s_lost;
    end
    path_evt = redge && path_evt && !s_lost;
    sync_evt = redge && sync_evt;
    febe_evt = redge && s_febe && !s_lost;
  end

  assign cif.inc = {febe_evt, sync_evt, path_evt, lif.line_evt};

  lec_counter_bank #(.N(`LEC_NUM_CNT), .W(W)) u_bank (
    .sys_clk_i (sys_clk_i),
    .rst_i     (rst_i),
    .cif       (cif)
  );

  // update timing
  always_comb begin
    if (!cfg_q[`LEC_BIT_INTERVAL]) begin
      frame_lim = 13'(FRAMES_SECOND);
    end else if (s_t1) begin
      frame_lim = 13'(FRAMES_T1_SHORT);
    end else begin
      frame_lim = 13'(FRAMES_E1_SHORT);
    end
  end

  assign auto_hit = !cfg_q[`LEC_BIT_ACC_MODE] && redge && s_frm && (frame_cnt_q + 13'h0001 >= frame_lim);
  assign man_hit  = cfg_q[`LEC_BIT_ACC_MODE] && cfg_q[`LEC_BIT_MANUAL] && !manual_q;
  assign snap     = auto_hit || man_hit;
  assign cif.snap = snap;

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      frame_cnt_q <= 13'h0000;
    end else if (cfg_q[`LEC_BIT_ACC_MODE] || auto_hit) begin
      frame_cnt_q <= 13'h0000;
    end else if (redge && s_frm) begin
      frame_cnt_q <= frame_cnt_q + 13'h0001;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      manual_q <= 1'b0;
    end else begin
      manual_q <= cfg_q[`LEC_BIT_MANUAL];
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      update_strobe_o <= 1'b0;
    end else begin
      update_strobe_o <= auto_hit;
    end
  end

  // axi4-lite write channel
  logic        aw_held_q;
  logic        w_held_q;
  logic [7:0]  aw_idx_q;
  logic [7:0]  wdata_q;
  logic        wstrb0_q;
  logic        wr_go;
  logic        aw_ok;

  assign s_axi_awready_o = !aw_held_q && !s_axi_bvalid_o;
  assign s_axi_wready_o  = !w_held_q && !s_axi_bvalid_o;
  assign wr_go           = aw_held_q && w_held_q && !s_axi_bvalid_o;
  assign aw_ok           = (aw_idx_q == `LEC_IDX_CFG) || (aw_idx_q == `LEC_IDX_STATUS);

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      aw_held_q <= 1'b0;
      w_held_q  <= 1'b0;
      aw_idx_q  <= 8'h00;
      wdata_q   <= 8'h00;
      wstrb0_q  <= 1'b0;
    end else begin
      if (s_axi_awvalid_i && s_axi_awready_o) begin
        aw_held_q <= 1'b1;
        aw_idx_q  <= s_axi_awaddr_i[9:2];
      end
      if (s_axi_wvalid_i && s_axi_wready_o) begin
        w_held_q <= 1'b1;
        wdata_q  <= s_axi_wdata_i[7:0];
        wstrb0_q <= s_axi_wstrb_i[0];
      end
      if (wr_go) begin
        aw_held_q <= 1'b0;
        w_held_q  <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_bvalid_o <= 1'b0;
      s_axi_bresp_o  <= LEC_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid_o <= 1'b1;
      s_axi_bresp_o  <= aw_ok ? LEC_RESP_OKAY : LEC_RESP_SLVERR;
    end else if (s_axi_bready_i) begin
      s_axi_bvalid_o <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      cfg_q <= `LEC_CFG_RESET;
    end else if (wr_go && wstrb0_q && (aw_idx_q == `LEC_IDX_CFG)) begin
      cfg_q <= wdata_q & `LEC_CFG_WMASK;
    end
  end

  // update flag: set wins over write-one clear
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      upd_flag_q <= 1'b0;
    end else if (snap) begin
      upd_flag_q <= 1'b1;
    end else if (wr_go && wstrb0_q && (aw_idx_q == `LEC_IDX_STATUS) && wdata_q[`LEC_BIT_ST_UPDATE]) begin
      upd_flag_q <= 1'b0;
    end
  end

  // axi4-lite read channel
  logic [7:0] rd_byte;
  logic       rd_ok;
  logic [7:0] ar_idx;

  assign s_axi_arready_o = !s_axi_rvalid_o;
  assign ar_idx          = s_axi_araddr_i[9:2];

  always_comb begin
    rd_ok = 1'b1;
    case (ar_idx)
      `LEC_IDX_CFG:     rd_byte = cfg_q;
      `LEC_IDX_LINE_HI: rd_byte = cif.held[15:8];
      `LEC_IDX_LINE_LO: rd_byte = cif.held[7:0];
      `LEC_IDX_PATH_HI: rd_byte = cif.held[31:24];
      `LEC_IDX_PATH_LO: rd_byte = cif.held[23:16];
      `LEC_IDX_SYNC_HI: rd_byte = cif.held[47:40];
      `LEC_IDX_SYNC_LO: rd_byte = cif.held[39:32];
      `LEC_IDX_FEBE_HI: rd_byte = cif.held[63:56];
      `LEC_IDX_FEBE_LO: rd_byte = cif.held[55:48];
      `LEC_IDX_STATUS:  rd_byte = {6'h00, s_lost, upd_flag_q};
      default: begin
        rd_byte = 8'h00;
        rd_ok   = 1'b0;
      end
    endcase
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      s_axi_rvalid_o <= 1'b0;
      s_axi_rdata_o  <= 32'h00000000;
      s_axi_rresp_o  <= LEC_RESP_OKAY;
    end else if (s_axi_arvalid_i && s_axi_arready_o) begin
      s_axi_rvalid_o <= 1'b1;
      s_axi_rdata_o  <= {24'h000000, rd_byte};
      s_axi_rresp_o  <= rd_ok ? LEC_RESP_OKAY : LEC_RESP_SLVERR;
    end else if (s_axi_rready_i) begin
      s_axi_rvalid_o <= 1'b0;
    end
  end
endmodule

// ### hdl/lec_params.svh
`ifndef LEC_PARAMS_SVH
`define LEC_PARAMS_SVH

// register indices (byte address = 4 * index)
`define LEC_IDX_CFG        8'h41
`define LEC_IDX_LINE_HI    8'h42
`define LEC_IDX_LINE_LO    8'h43
`define LEC_IDX_PATH_HI    8'h44
`define LEC_IDX_PATH_LO    8'h45
`define LEC_IDX_SYNC_HI    8'h46
`define LEC_IDX_SYNC_LO    8'h47
`define LEC_IDX_STATUS     8'h50
`define LEC_IDX_FEBE_HI    8'h51
`define LEC_IDX_FEBE_LO    8'h52

// config fields
`define LEC_CFG_RESET      8'h00
`define LEC_CFG_WMASK      8'h7F
`define LEC_BIT_T1_ZERO    0
`define LEC_BIT_SYNC_FN    1
`define LEC_BIT_FS_REPORT  2
`define LEC_BIT_E1_VTYPE   3
`define LEC_BIT_ACC_MODE   4
`define LEC_BIT_INTERVAL   5
`define LEC_BIT_MANUAL     6

// status fields
`define LEC_BIT_ST_UPDATE  0
`define LEC_BIT_ST_SYNC    1

// timing in receive frames
`define LEC_FRAMES_SECOND  8000
`define LEC_FRAMES_T1_SHORT 333
`define LEC_FRAMES_E1_SHORT 500

// excessive-zero run lengths
`define LEC_EXZ_PLAIN      16
`define LEC_EXZ_B8ZS       8

`define LEC_CNT_WIDTH      16
`define LEC_NUM_CNT        4

`endif

// ### hdl/lec_pkg.sv
package lec_pkg;
  typedef enum logic [1:0] {
    LEC_SYM_ZERO = 2'b00,
    LEC_SYM_POS  = 2'b01,
    LEC_SYM_NEG  = 2'b10
  } lec_sym_t;

  typedef enum logic [1:0] {
    LEC_RESP_OKAY   = 2'b00,
    LEC_RESP_SLVERR = 2'b10
  } lec_resp_t;

  typedef enum logic [1:0] {
    LEC_CNT_LINE = 2'b00,
    LEC_CNT_PATH = 2'b01,
    LEC_CNT_SYNC = 2'b10,
    LEC_CNT_FEBE = 2'b11
  } lec_cnt_sel_t;
endpackage

// ### hdl/lec_if.sv
interface lec_line_if;
  logic       sample;
  logic       rpos;
  logic       rneg;
  logic       t1_mode;
  logic       b8zs_en;
  logic       hdb3_en;
  logic       zero_count_en;
  logic       cv_mode;
  logic       line_evt;
  modport ctl (output sample, rpos, rneg, t1_mode, b8zs_en, hdb3_en, zero_count_en, cv_mode, input line_evt);
  modport dec (input sample, rpos, rneg, t1_mode, b8zs_en, hdb3_en, zero_count_en, cv_mode, output line_evt);
endinterface

interface lec_cnt_if #(parameter int N = 4, parameter int W = 16);
  logic [N-1:0]   inc;
  logic           snap;
  logic [N*W-1:0] held;
  modport ctl (output inc, snap, input held);
  modport cnt (input inc, snap, output held);
endinterface

// ### hdl/lec_line_decoder.sv
`include "lec_params.svh"

module lec_line_decoder (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  lec_line_if.dec   lif
);
  import lec_pkg::*;

  lec_sym_t   sym;
  lec_sym_t   last_mark_q;
  lec_sym_t   last_bpv_q;
  lec_sym_t   hist_q [0:7];
  logic [7:0] pend_q;
  logic [4:0] zrun_q;
  logic       bpv;
  logic       b8zs_hit;
  logic       hdb3_hit;
  logic       exz_hit;
  logic       cv_hit;
  logic [4:0] exz_len;

  always_comb begin
    sym = lif.rpos ? LEC_SYM_POS : (lif.rneg ? LEC_SYM_NEG : LEC_SYM_ZERO);
    if (lif.rpos && lif.rneg) begin
      sym = LEC_SYM_ZERO;
    end
    bpv     = (sym != LEC_SYM_ZERO) && (sym == last_mark_q);
    exz_len = lif.b8zs_en ? 5'(`LEC_EXZ_B8ZS) : 5'(`LEC_EXZ_PLAIN);
    exz_hit = lif.t1_mode && lif.zero_count_en && (sym == LEC_SYM_ZERO) && (zrun_q + 5'h01 == exz_len);
    // 000VB0VB completes with the newest symbol
    b8zs_hit = lif.t1_mode && lif.b8zs_en && (sym != LEC_SYM_ZERO) && (hist_q[0] != LEC_SYM_ZERO)
               && (hist_q[0] != sym) && (hist_q[1] == LEC_SYM_ZERO) && (hist_q[2] == hist_q[0])
               && (hist_q[3] != hist_q[2]) && (hist_q[3] != LEC_SYM_ZERO) && (hist_q[4] == LEC_SYM_ZERO)
               && (hist_q[5] == LEC_SYM_ZERO) && (hist_q[6] == LEC_SYM_ZERO);
    // 000V or B00V with V the newest symbol
    hdb3_hit = !lif.t1_mode && lif.hdb3_en && !lif.cv_mode && bpv
               && (hist_q[0] == LEC_SYM_ZERO) && (hist_q[1] == LEC_SYM_ZERO);
    cv_hit   = !lif.t1_mode && lif.cv_mode && bpv && (sym == last_bpv_q);
  end

  // violation flags wait eight symbols so a codeword can withdraw them
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      pend_q <= 8'h00;
    end else if (lif.sample) begin
      pend_q <= {pend_q[6:0], (bpv && !hdb3_hit && (lif.t1_mode || !lif.cv_mode)) || exz_hit || cv_hit};
      if (b8zs_hit) begin
        pend_q[1] <= 1'b0;
        pend_q[4] <= 1'b0;
      end
    end
  end

  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      for (int i = 0; i < 8; i++) begin
        hist_q[i] <= LEC_SYM_ZERO;
      end
      last_mark_q <= LEC_SYM_ZERO;
      last_bpv_q  <= LEC_SYM_ZERO;
      zrun_q      <= 5'h00;
    end else if (lif.sample) begin
      hist_q[0] <= sym;
      for (int i = 1; i < 8; i++) begin
        hist_q[i] <= hist_q[i-1];
      end
      if (sym != LEC_SYM_ZERO) begin
        last_mark_q <= sym;
        zrun_q      <= 5'h00;
      end else if (zrun_q != 5'h1F) begin
        zrun_q <= zrun_q + 5'h01;
      end
      if (bpv) begin
        last_bpv_q <= sym;
      end
    end
  end

  // no sync gating: line errors count at all times
  always_ff @(posedge sys_clk_i) begin
    if (rst_i) begin
      lif.line_evt <= 1'b0;
    end else begin
      lif.line_evt <= lif.sample && pend_q[7];
    end
  end
endmodule

// ### hdl/lec_counter_bank.sv
`include "lec_params.svh"

module lec_counter_bank #(
  parameter int N = `LEC_NUM_CNT,
  parameter int W = `LEC_CNT_WIDTH
) (
  input  wire logic sys_clk_i,
  input  wire logic rst_i,
  lec_cnt_if.cnt    cif
);
  import lec_pkg::*;

  for (genvar g = 0; g < N; g++) begin : g_cnt
    logic [W-1:0] run_q;
    logic [W-1:0] held_q;
    logic [W-1:0] run_next;

    always_comb begin
      run_next = run_q;
      if (cif.inc[g] && (run_q != {W{1'b1}})) begin
        run_next = run_q + W'(1);
      end
    end

    always_ff @(posedge sys_clk_i) begin
      if (rst_i) begin
        run_q  <= '0;
        held_q <= '0;
      end else if (cif.snap) begin
        held_q <= run_next;
        run_q  <= '0;
      end else begin
        run_q <= run_next;
      end
    end

    assign cif.held[g*W +: W] = held_q;
  end
endmodule

// ### verification/lec_top_asserts.sv
module lec_top_asserts (
  input wire logic        sys_clk_i,
  input wire logic        rst_i,
  input wire logic [9:0]  s_axi_araddr_i,
  input wire logic        s_axi_arvalid_i,
  input wire logic        s_axi_arready_o,
  input wire logic [31:0] s_axi_rdata_o,
  input wire logic [1:0]  s_axi_rresp_o,
  input wire logic        s_axi_rvalid_o,
  input wire logic        s_axi_rready_i,
  input wire logic        s_axi_awvalid_i,
  input wire logic        s_axi_awready_o,
  input wire logic        s_axi_wvalid_i,
  input wire logic        s_axi_wready_o,
  input wire logic [1:0]  s_axi_bresp_o,
  input wire logic        s_axi_bvalid_o,
  input wire logic        s_axi_bready_i,
  input wire logic        update_strobe_o
);
  logic unmapped;
  default clocking cb @(posedge sys_clk_i);
  endclocking
  default disable iff (rst_i);
  assign unmapped = !(s_axi_araddr_i[9:2] inside {[8'h41:8'h47], [8'h50:8'h52]});
  sequence rd_take;
    s_axi_arvalid_i && s_axi_arready_o;
  endsequence
  sequence wr_take;
    s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i && s_axi_wready_o;
  endsequence
  rd_answer_a: assert property (rd_take |=> s_axi_rvalid_o)
    else $error("read not answered");
  rd_hold_a: assert property (s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o))
    else $error("read data dropped");
  rd_block_a: assert property (s_axi_rvalid_o |-> !s_axi_arready_o)
    else $error("read taken while busy");
  byte_reg_a: assert property (s_axi_rvalid_o |-> s_axi_rdata_o[31:8] == 24'h0)
    else $error("upper read bits set");
  unmapped_err_a: assert property (rd_take ##0 unmapped |=> s_axi_rresp_o == 2'h2)
    else $error("unmapped read not refused");
  wr_answer_a: assert property (wr_take |-> ##[1:3] s_axi_bvalid_o)
    else $error("write not answered");
  wr_hold_a: assert property (s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o))
    else $error("write response dropped");
  wr_block_a: assert property (s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o)
    else $error("write taken while busy");
  strobe_pulse_a: assert property ($rose(update_strobe_o) |=> !update_strobe_o [*8])
    else $error("update strobe too long or too close");
endmodule

bind lec_top lec_top_asserts u_asserts (
  .sys_clk_i, .rst_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
  .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .s_axi_awvalid_i, .s_axi_awready_o,
  .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .update_strobe_o
);

// ### verification/lec_line_model.sv
module lec_line_model #(
  parameter int FRAME_LEN = 8
) (
  output logic       rclk_o,
  output logic       rpos_o,
  output logic       rneg_o,
  output logic       frame_tick_o,
  output logic [5:0] err_o
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [1:0] sym_q[$];
  logic [1:0] sym;
  logic [5:0] err_req = 6'h00;
  logic       pol = 1'h0;
  int         bit_n = 0;
  initial begin
    rpos_o = 1'h0;
    rneg_o = 1'h0;
    frame_tick_o = 1'h0;
    err_o = 6'h00;
    rclk_o = 1'h0;
    #17;
    forever #62.5 rclk_o = ~rclk_o;
  end
  // symbols: 0 zero, 1 alternating mark, 2 mark of repeated polarity
  always @(negedge rclk_o) begin
    sym = (sym_q.size() > 0) ? sym_q.pop_front() : 2'h1;
    if (sym == 2'h1) pol = ~pol;
    rpos_o <= (sym != 2'h0) && pol;
    rneg_o <= (sym != 2'h0) && !pol;
    bit_n = (bit_n + 1) % FRAME_LEN;
    frame_tick_o <= (bit_n == 0);
    err_o <= err_req;
    err_req = 6'h00;
  end
  task automatic push(input logic [1:0] s, input int n);
    repeat (n) sym_q.push_back(s);
  endtask
  task automatic pulse_err(input logic [5:0] e);
    @(posedge rclk_o);
    err_req = e;
    repeat (2) @(negedge rclk_o);
  endtask
endmodule

// ### verification/lec_top_tb.sv
`include "lec_params.svh"

module lec_top_tb;
  timeunit 1ns;
  timeprecision 100ps;
  import lec_pkg::*;
  localparam int FS = 4;
  localparam int T1S = 3;
  localparam int E1S = 5;
  localparam int FLEN = 8;
  localparam int FCYC = FLEN * 125 / 10;
  logic        sys_clk_i = 1'h0, rst_i = 1'h1, t1_mode_i = 1'h1, receive_sync_lost_i = 1'h0;
  logic        b8zs_en_i = 1'h0, hdb3_en_i = 1'h0, esf_mode_i = 1'h1;
  logic [9:0]  s_axi_awaddr_i = '0, s_axi_araddr_i = '0;
  logic [31:0] s_axi_wdata_i = '0, s_axi_rdata_o;
  logic [3:0]  s_axi_wstrb_i = 4'hF, strb = 4'hF;
  logic [1:0]  s_axi_bresp_o, s_axi_rresp_o;
  logic        s_axi_awvalid_i = 1'h0, s_axi_wvalid_i = 1'h0, s_axi_bready_i = 1'h0;
  logic        s_axi_arvalid_i = 1'h0, s_axi_rready_i = 1'h0;
  logic        s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o, s_axi_arready_o, s_axi_rvalid_o;
  logic        rclk_i, rpos_i, rneg_i, frame_tick_i, update_strobe_o;
  logic [5:0]  err;
  logic [33:0] notes[$];
  logic [1:0]  cw[8] = '{2'h0, 2'h0, 2'h0, 2'h2, 2'h1, 2'h0, 2'h2, 2'h1};
  logic [7:0]  lo_idx[4] = '{`LEC_IDX_LINE_LO, `LEC_IDX_PATH_LO, `LEC_IDX_SYNC_LO, `LEC_IDX_FEBE_LO};
  logic [7:0]  auto_cfg[4] = '{8'h00, 8'h20, 8'h20, 8'h00};
  logic        auto_t1[4] = '{1'h1, 1'h1, 1'h0, 1'h0};
  int          auto_fr[4] = '{FS, T1S, E1S, FS};
  int          fail_count = 0, checked = 0, cyc = 0, seed = 77, n, gap, q;

  lec_top #(.FRAMES_SECOND(FS), .FRAMES_T1_SHORT(T1S), .FRAMES_E1_SHORT(E1S)) u_dut (
    .sys_clk_i, .rst_i, .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
    .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o, .s_axi_bvalid_o,
    .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i, .s_axi_arready_o, .s_axi_rdata_o,
    .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i, .rclk_i, .rpos_i, .rneg_i, .t1_mode_i,
    .esf_mode_i, .b8zs_en_i, .hdb3_en_i, .receive_sync_lost_i, .frame_tick_i,
    .multiframe_tick_i(1'h0), .crc_err_i(err[5]), .ft_err_i(err[4]), .fs_err_i(err[3]),
    .fps_err_i(err[2]), .fas_err_i(err[1]), .far_end_err_i(err[0]), .update_strobe_o
  );
  lec_line_model #(.FRAME_LEN(FLEN)) u_line (
    .rclk_o(rclk_i), .rpos_o(rpos_i), .rneg_o(rneg_i), .frame_tick_o(frame_tick_i), .err_o(err)
  );

  always #5 sys_clk_i = ~sys_clk_i;

  task automatic check(input logic [33:0] seen, input logic [33:0] exp);
    checked++;
    if (seen !== exp) begin
      fail_count++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    $display("checks %0d mismatches %0d", checked, fail_count);
    if (fail_count == 0 && checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask

  task automatic xfer(input bit wr, input logic [7:0] idx, input logic [7:0] d, input lec_resp_t r);
    logic a, w, b;
    notes.push_back({wr ? 32'h0 : {24'h0, d}, r});
    @(posedge sys_clk_i);
    if (wr) begin
      s_axi_awaddr_i <= {idx, 2'h0};
      s_axi_wdata_i <= {24'($random(seed)), d};
      s_axi_wstrb_i <= strb;
      s_axi_awvalid_i <= 1'h1;
      s_axi_wvalid_i <= 1'h1;
      s_axi_bready_i <= 1'h1;
    end else begin
      s_axi_araddr_i <= {idx, 2'h0};
      s_axi_arvalid_i <= 1'h1;
      s_axi_rready_i <= 1'h1;
    end
    do begin
      @(negedge sys_clk_i);
      a = wr ? s_axi_awready_o : s_axi_arready_o;
      w = s_axi_wready_o;
      b = wr ? s_axi_bvalid_o : s_axi_rvalid_o;
      @(posedge sys_clk_i);
      if (a && wr) s_axi_awvalid_i <= 1'h0;
      if (a && !wr) s_axi_arvalid_i <= 1'h0;
      if (w && wr) s_axi_wvalid_i <= 1'h0;
    end while (b !== 1'h1);
    s_axi_bready_i <= 1'h0;
    s_axi_rready_i <= 1'h0;
  endtask

  task automatic strobe_gap(output int g);
    g = 0;
    do begin
      @(negedge sys_clk_i);
      g++;
    end while (update_strobe_o !== 1'h1 && g < 2000);
  endtask

  always @(posedge sys_clk_i) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      fail_count++;
      close_out();
    end
  end

  // result watcher: oldest note against each response
  always @(negedge sys_clk_i) begin
    if (s_axi_bvalid_o === 1'h1 && s_axi_bready_i) check({32'h0, s_axi_bresp_o}, notes.pop_front());
    if (s_axi_rvalid_o === 1'h1 && s_axi_rready_i) check({s_axi_rdata_o, s_axi_rresp_o}, notes.pop_front());
  end

  initial begin
    repeat (20) @(posedge sys_clk_i);
    rst_i <= 1'h0;
    xfer(1'h0, `LEC_IDX_CFG, 8'h00, LEC_RESP_OKAY);
    xfer(1'h0, 8'h60, 8'h00, LEC_RESP_SLVERR);
    xfer(1'h1, `LEC_IDX_LINE_LO, 8'h55, LEC_RESP_SLVERR);
    xfer(1'h1, `LEC_IDX_CFG, 8'h7F, LEC_RESP_OKAY);
    strb = 4'hE;
    xfer(1'h1, `LEC_IDX_CFG, 8'h10, LEC_RESP_OKAY);
    strb = 4'hF;
    xfer(1'h0, `LEC_IDX_CFG, 8'h7F, LEC_RESP_OKAY);
    xfer(1'h1, `LEC_IDX_STATUS, 8'h01, LEC_RESP_OKAY);
    xfer(1'h0, `LEC_IDX_STATUS, 8'h00, LEC_RESP_OKAY);
    for (int p = 0; p < 4; p++) begin
      n = 1 + {$random(seed)} % 6;
      q = (p == 1 || p == 2);
      receive_sync_lost_i <= (p == 0);
      b8zs_en_i <= (p == 2);
      esf_mode_i <= (p != 2);
      hdb3_en_i <= (p == 3);
      t1_mode_i <= (p != 3);
      xfer(1'h1, `LEC_IDX_CFG, 8'(8'h10 + q), LEC_RESP_OKAY);
      u_line.push(2'h2, n);
      if (p > 1) for (int k = 0; k < (8 >> (p - 2)); k++) u_line.push(cw[k], 1);
      u_line.push(2'h0, (p == 1) ? 16 : 8 * (p == 2));
      repeat (2) u_line.pulse_err(6'h3F);
      wait (u_line.sym_q.size() == 0);
      repeat (250) @(posedge sys_clk_i);
      xfer(1'h1, `LEC_IDX_CFG, 8'(8'h50 + q), LEC_RESP_OKAY);
      repeat (20) @(posedge sys_clk_i);
      xfer(1'h0, `LEC_IDX_LINE_HI, 8'h00, LEC_RESP_OKAY);
      for (int i = 0; i < 4; i++) xfer(1'h0, lo_idx[i], i ? 8'(2 * (p > 0)) : 8'(n + q), LEC_RESP_OKAY);
    end
    for (int i = 0; i < 4; i++) begin
      t1_mode_i <= auto_t1[i];
      xfer(1'h1, `LEC_IDX_CFG, auto_cfg[i], LEC_RESP_OKAY);
      strobe_gap(gap);
      strobe_gap(gap);
      check(34'((gap + FCYC / 2) / FCYC), 34'(auto_fr[i]));
    end
    xfer(1'h0, `LEC_IDX_STATUS, 8'h01, LEC_RESP_OKAY);
    close_out();
  end
endmodule
